// *** fsg_consts.svh ***
// constants for the flash segment write guard
`ifndef FSG_CONSTS_SVH
`define FSG_CONSTS_SVH
`define FSG_ADDR_W        24
`define FSG_PAGE_SHIFT    9
`define FSG_PAGE_W        8
`define FSG_PAGE_WORDS    24'h000200
`define FSG_LAST_ADDR     24'h02ABFF
`define FSG_CFG_W         16
`define FSG_CFG_WORDS     3
`define FSG_CFG_BASE      24'h02ABFA
`define FSG_APB_ADDR_W    8
`define FSG_OFF_CFG0      8'h00
`define FSG_OFF_STATUS    8'h0C
`define FSG_OFF_RELOAD    8'h10
`define FSG_CFG_RESET     16'hFFFF
`define FSG_BIT_GCP_N     0
`define FSG_BIT_GENERAL_WRITE_PROTECT_N_N    1
`define FSG_BIT_SPDIS     0
`define FSG_BIT_BSEL      1
`define FSG_BIT_LPP_N     2
`define FSG_POS_PAGE      8
`define FSG_RST_PULSE     4'h4
`endif

// *** fsg_pkg.sv ***
// types for the flash segment write guard
package fsg_pkg;
   typedef enum logic [1:0] {
      FSG_ST_IDLE = 2'b00,
      FSG_ST_REQ  = 2'b01,
      FSG_ST_WAIT = 2'b10,
      FSG_ST_RUN  = 2'b11
   } fsg_load_e;
   typedef struct packed {
      logic        valid;
      logic        erase;
      logic [23:0] addr;
   } fsg_wr_req_s;
   typedef struct packed {
      logic valid;
      logic blocked;
   } fsg_wr_ans_s;
endpackage : fsg_pkg

// *** fsg_cfg_store.sv ***
// configuration register bank with complemented shadow copies
`timescale 1ns/1ns
`include "fsg_consts.svh"
module fsg_cfg_store
(
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // load port
   input  wire logic                     ld_en,
   input  wire logic [1:0]               ld_idx,
   input  wire logic [`FSG_CFG_W-1:0]    ld_data,
   // active values and compare result
   output logic [3*`FSG_CFG_W-1:0]       cfg_val,
   output logic                          mismatch
);
   logic [`FSG_CFG_W-1:0] act_reg  [0:2];
   logic [`FSG_CFG_W-1:0] shd_reg  [0:2];
   logic [`FSG_CFG_W-1:0] act_next [0:2];
   logic [`FSG_CFG_W-1:0] shd_next [0:2];
   logic                  mis_next;
   logic                  mis_reg;

   always_comb
   begin
      mis_next = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         act_next[i] = act_reg[i];
         shd_next[i] = shd_reg[i];
         if (ld_en && ld_idx == 2'(i))
         begin
            act_next[i] = ld_data;
            shd_next[i] = ~ld_data;
         end
         // continuous compare of value against complement
         if ((act_reg[i] ^ shd_reg[i]) != {`FSG_CFG_W{1'b1}})
            mis_next = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < 3; i++)
         begin
            act_reg[i] <= `FSG_CFG_RESET;
            shd_reg[i] <= ~`FSG_CFG_RESET;
         end
         mis_reg <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < 3; i++)
         begin
            act_reg[i] <= act_next[i];
            shd_reg[i] <= shd_next[i];
         end
         mis_reg <= mis_next;
      end
   end

   always_comb
   begin
      cfg_val  = {act_reg[2], act_reg[1], act_reg[0]};
      mismatch = mis_reg;
   end
endmodule : fsg_cfg_store

// *** fsg_guard.sv ***
// flash segment write guard with configuration integrity monitor
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "fsg_consts.svh"
module fsg_guard
(
   // clock and reset
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [`FSG_APB_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]                 pwdata,
   output logic                             pready,
   output logic [31:0]                      prdata,
   output logic                             pslverr,
   // flash read port for configuration load
   output logic                             cfg_rd_req,
   output logic [`FSG_ADDR_W-1:0]           cfg_rd_addr,
   input  wire logic                        cfg_rd_valid,
   input  wire logic [`FSG_CFG_W-1:0]       cfg_rd_data,
   // programming controller request and answer
   input  wire fsg_pkg::fsg_wr_req_s        wr_req,
   output fsg_pkg::fsg_wr_ans_s             wr_ans,
   // external programming access check
   input  wire logic                        ext_req,
   input  wire logic [`FSG_ADDR_W-1:0]      ext_addr,
   output logic                             ext_deny,
   // integrity outputs
   output logic                             parity_err,
   output logic                             dev_reset_req
);
   import fsg_pkg::*;

   logic [3*`FSG_CFG_W-1:0] cfg_val;
   logic                    mismatch;
   logic                    ld_en;
   fsg_load_e               st_reg, st_next;
   logic [1:0]              idx_reg, idx_next;
   logic                    rd_req_reg, rd_req_next;
   logic                    perr_reg, perr_next;
   logic [3:0]              rst_cnt_reg, rst_cnt_next;
   fsg_wr_ans_s             ans_reg, ans_next;
   logic                    deny_reg, deny_next;
   logic                    pready_reg, pready_next;
   logic [31:0]             prdata_reg, prdata_next;
   logic                    pslverr_reg, pslverr_next;
   logic                    gcp_n, general_write_protect_n_n, spdis, bsel, lpp_n;
   logic [`FSG_PAGE_W-1:0]  bpage;
   logic [`FSG_ADDR_W-1:0]  addr_reg, addr_next;
   logic                    dev_rst_reg, dev_rst_next;

   fsg_cfg_store u_store
   (
      .pclk     (pclk),
      .presetn  (presetn),
      .ld_en    (ld_en),
      .ld_idx   (idx_reg),
      .ld_data  (cfg_rd_data),
      .cfg_val  (cfg_val),
      .mismatch (mismatch)
   );

   always_comb
   begin
      gcp_n  = cfg_val[`FSG_BIT_GCP_N];
      general_write_protect_n_n = cfg_val[`FSG_BIT_GENERAL_WRITE_PROTECT_N_N];
      spdis  = cfg_val[2*`FSG_CFG_W+`FSG_BIT_SPDIS];
      bsel   = cfg_val[2*`FSG_CFG_W+`FSG_BIT_BSEL];
      lpp_n  = cfg_val[2*`FSG_CFG_W+`FSG_BIT_LPP_N];
      bpage  = cfg_val[2*`FSG_CFG_W+`FSG_POS_PAGE +: `FSG_PAGE_W];
   end

   // page number of a word address
   function automatic logic [`FSG_ADDR_W-1:0] page_of(input logic [`FSG_ADDR_W-1:0] a);
      page_of = a >> `FSG_PAGE_SHIFT;
   endfunction : page_of

   function automatic logic seg_block(input logic [`FSG_ADDR_W-1:0] a,
                                      input logic sd, input logic bs,
                                      input logic lp, input logic [7:0] pg);
      logic [`FSG_ADDR_W-1:0] ap;
      logic [`FSG_ADDR_W-1:0] bp;
      logic [`FSG_ADDR_W-1:0] lastp;
      ap    = page_of(a);
      bp    = {16'h0000, pg};
      lastp = page_of(`FSG_LAST_ADDR);
      seg_block = 1'b0;
      if (!sd)
      begin
         if (bs)
            seg_block = (ap >= bp);
         else
            seg_block = (ap <= bp) || (!lp && ap == lastp);
      end
   endfunction : seg_block

   // configuration load sequencer
   always_comb
   begin
      st_next     = st_reg;
      idx_next    = idx_reg;
      rd_req_next = 1'b0;
      ld_en       = 1'b0;
      unique case (st_reg)
         FSG_ST_IDLE: st_next = FSG_ST_REQ;
         FSG_ST_REQ:
         begin
            rd_req_next = 1'b1;
            st_next     = FSG_ST_WAIT;
         end
         FSG_ST_WAIT:
            if (cfg_rd_valid)
            begin
               ld_en = 1'b1;
               if (idx_reg == 2'(`FSG_CFG_WORDS-1))
                  st_next = FSG_ST_RUN;
               else
               begin
                  idx_next = idx_reg + 2'b01;
                  st_next  = FSG_ST_REQ;
               end
            end
         FSG_ST_RUN:
            if (psel && penable && pwrite && paddr == `FSG_OFF_RELOAD && pwdata[0])
            begin
               idx_next = 2'b00;
               st_next  = FSG_ST_REQ;
            end
      endcase
      addr_next = `FSG_CFG_BASE + {22'h000000, idx_next};
   end

   // guard, integrity and bus next values
   always_comb
   begin
      logic blk;
      blk          = 1'b0;
      ans_next     = '0;
      perr_next    = perr_reg | (mismatch & st_reg == FSG_ST_RUN);
      rst_cnt_next = (rst_cnt_reg != 4'h0) ? rst_cnt_reg - 4'h1 : 4'h0;
      if (mismatch && !perr_reg && st_reg == FSG_ST_RUN)
         rst_cnt_next = `FSG_RST_PULSE;
      dev_rst_next = (rst_cnt_next != 4'h0);
      if (wr_req.valid)
      begin
         // general write protect first, segment only adds
         blk = !general_write_protect_n_n || st_reg != FSG_ST_RUN;
         blk = blk | seg_block(wr_req.addr, spdis, bsel, lpp_n, bpage);
         ans_next.valid   = 1'b1;
         ans_next.blocked = blk;
      end
      deny_next    = ext_req && (!gcp_n || st_reg != FSG_ST_RUN);
      pready_next  = psel && !penable;
      prdata_next  = prdata_reg;
      pslverr_next = 1'b0;
      if (psel && !penable)
      begin
         unique case (paddr)
            8'h00, 8'h04, 8'h08:
               prdata_next = {16'h0000, cfg_val[paddr[3:2]*`FSG_CFG_W +: `FSG_CFG_W]};
            `FSG_OFF_STATUS:
               prdata_next = {29'h0, st_reg == FSG_ST_RUN, mismatch, perr_reg};
            `FSG_OFF_RELOAD: prdata_next = 32'h0;
            default:
            begin
               prdata_next  = 32'h0;
               pslverr_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg      <= FSG_ST_IDLE;
         idx_reg     <= 2'b00;
         rd_req_reg  <= 1'b0;
         perr_reg    <= 1'b0;
         rst_cnt_reg <= 4'h0;
         ans_reg     <= '0;
         deny_reg    <= 1'b0;
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0;
         pslverr_reg <= 1'b0;
         addr_reg    <= `FSG_CFG_BASE;
         dev_rst_reg <= 1'b0;
      end
      else
      begin
         st_reg      <= st_next;
         idx_reg     <= idx_next;
         rd_req_reg  <= rd_req_next;
         perr_reg    <= perr_next;
         rst_cnt_reg <= rst_cnt_next;
         ans_reg     <= ans_next;
         deny_reg    <= deny_next;
         pready_reg  <= pready_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
         addr_reg    <= addr_next;
         dev_rst_reg <= dev_rst_next;
      end
   end

   always_comb
   begin
      cfg_rd_req    = rd_req_reg;
      cfg_rd_addr   = addr_reg;
      wr_ans        = ans_reg;
      ext_deny      = deny_reg;
      parity_err    = perr_reg;
      dev_reset_req = dev_rst_reg;
      pready        = pready_reg;
      prdata        = prdata_reg;
      pslverr       = pslverr_reg;
   end

   property p_general_write_protect_n_blocks;
      @(posedge pclk) disable iff (!presetn)
      (wr_req.valid && !general_write_protect_n_n) |=> (wr_ans.valid && wr_ans.blocked);
   endproperty
   a_general_write_protect_n_blocks: assert property (p_general_write_protect_n_blocks) else $error("write not blocked");
   property p_disable_free;
      @(posedge pclk) disable iff (!presetn)
      (wr_req.valid && spdis && general_write_protect_n_n && st_reg == FSG_ST_RUN) |=> !wr_ans.blocked;
   endproperty
   a_disable_free: assert property (p_disable_free) else $error("extra block");
   property p_top_range;
      @(posedge pclk) disable iff (!presetn)
      (wr_req.valid && !spdis && bsel && page_of(wr_req.addr) >= {16'h0, bpage})
      |=> wr_ans.blocked;
   endproperty
   a_top_range: assert property (p_top_range) else $error("top range open");
   property p_low_range;
      @(posedge pclk) disable iff (!presetn)
      (wr_req.valid && !spdis && !bsel && page_of(wr_req.addr) <= {16'h0, bpage})
      |=> wr_ans.blocked;
   endproperty
   a_low_range: assert property (p_low_range) else $error("low range open");
   property p_last_page;
      @(posedge pclk) disable iff (!presetn)
      (wr_req.valid && !spdis && !bsel && !lpp_n
       && page_of(wr_req.addr) == page_of(`FSG_LAST_ADDR)) |=> wr_ans.blocked;
   endproperty
   a_last_page: assert property (p_last_page) else $error("last page open");
   property p_mismatch_err;
      @(posedge pclk) disable iff (!presetn)
      (mismatch && st_reg == FSG_ST_RUN) |=> parity_err;
   endproperty
   a_mismatch_err: assert property (p_mismatch_err) else $error("no parity error");
   property p_reset_req;
      @(posedge pclk) disable iff (!presetn)
      $rose(parity_err) |-> dev_reset_req [*4];
   endproperty
   a_reset_req: assert property (p_reset_req) else $error("no reset pulse");
   property p_ext_deny;
      @(posedge pclk) disable iff (!presetn)
      (ext_req && !gcp_n) |=> ext_deny;
   endproperty
   a_ext_deny: assert property (p_ext_deny) else $error("access not denied");
   property p_load_done;
      @(posedge pclk) disable iff (!presetn)
      $rose(st_reg == FSG_ST_RUN) |-> $past(ld_en);
   endproperty
   a_load_done: assert property (p_load_done) else $error("run without load");
   c_blocked:  cover property (@(posedge pclk) wr_ans.valid && wr_ans.blocked);
   c_allowed:  cover property (@(posedge pclk) wr_ans.valid && !wr_ans.blocked);
   c_perr:     cover property (@(posedge pclk) $rose(parity_err));
   c_run:      cover property (@(posedge pclk) st_reg == FSG_ST_RUN);
endmodule : fsg_guard

// *** fsg_flash_model.sv ***
// flash configuration word source answering the guard's load reads
`timescale 1ns/1ns
`include "fsg_consts.svh"
module fsg_flash_model
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // configuration read port
   input  wire logic        cfg_rd_req,
   input  wire logic [23:0] cfg_rd_addr,
   output logic             cfg_rd_valid,
   output logic [15:0]      cfg_rd_data,
   // stored words and answer delay
   input  wire logic [15:0] word0,
   input  wire logic [15:0] word1,
   input  wire logic [15:0] word2,
   input  wire logic [7:0]  lat
);
   logic       busy;
   logic [7:0] cnt;
   logic [1:0] sel;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         busy         <= 1'b0;
         cnt          <= 8'h00;
         sel          <= 2'h0;
         cfg_rd_valid <= 1'b0;
         cfg_rd_data  <= 16'h0000;
      end
      else
      begin
         cfg_rd_valid <= 1'b0;
         // data line toggles between answers so a stale word never passes
         cfg_rd_data  <= ~cfg_rd_data;
         if (cfg_rd_req)
         begin
            busy <= 1'b1;
            cnt  <= lat;
            sel  <= 2'(cfg_rd_addr - `FSG_CFG_BASE);
         end
         else if (busy && cnt != 8'h00)
            cnt <= cnt - 8'h01;
         else if (busy)
         begin
            busy         <= 1'b0;
            cfg_rd_valid <= 1'b1;
            cfg_rd_data  <= (sel == 2'h0) ? word0 : (sel == 2'h1) ? word1 : word2;
         end
      end
   end
endmodule : fsg_flash_model

// *** tb.sv ***
// self-checking testbench for the flash segment write guard
`timescale 1ns/1ns
`include "fsg_consts.svh"
module tb;
   import fsg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, b;
   logic        cfg_rd_req, cfg_rd_valid, ext_req, ext_deny, parity_err, dev_reset_req;
   logic [7:0]  paddr, lat;
   logic [31:0] pwdata, prdata, rd;
   logic [23:0] cfg_rd_addr, ext_addr;
   logic [15:0] cfg_rd_data, w0, w2;
   fsg_wr_req_s wr_req;
   fsg_wr_ans_s wr_ans;
   int          fails, total_checks, cyc, nrd;
   logic [23:0] addrs [9] = '{24'h000000, 24'h007FFF, 24'h008000, 24'h0081FF, 24'h008200,
                              24'h010000, 24'h02A9FF, 24'h02AA00, 24'h02ABFF};
   fsg_guard i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data, .wr_req,
      .wr_ans, .ext_req, .ext_addr, .ext_deny, .parity_err, .dev_reset_req);
   fsg_flash_model i_flash (.pclk, .presetn, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid,
      .cfg_rd_data, .word0(w0), .word1(16'h1234), .word2(w2), .lat);
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ceiling well above the longest expected run
   always @(posedge pclk)
   begin
      cyc++;
      if (cfg_rd_valid === 1'b1)
         nrd++;
      if (cyc == 20000)
      begin
         fails++;
         end_sim();
      end
   end
   task end_sim;
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready seen high ends this wait; only the bench timeout bounds it
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wreq(input logic [23:0] a, input logic er, output logic blk);
      @(posedge pclk);
      wr_req <= '{valid: 1'b1, erase: er, addr: a};
      @(posedge pclk);
      wr_req.valid <= 1'b0;
      @(negedge pclk);
      chk(wr_ans.valid, 32'h1);
      blk = wr_ans.blocked;
   endtask : wreq
   task ext(input logic [23:0] a, input logic exp);
      @(posedge pclk);
      ext_req <= 1'b1;
      ext_addr <= a;
      repeat (2) @(posedge pclk);
      chk(ext_deny, exp);
      ext_req <= 1'b0;
   endtask : ext
   task wait_load;
      int n;
      n = 0;
      while (nrd < 3 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      do
      begin
         apb(1'b0, `FSG_OFF_STATUS, 32'h0);
         n++;
      end
      while (rd[2] !== 1'b1 && n < 20);
      chk(rd, 32'h4);
   endtask : wait_load
   task load(input logic [15:0] c0, input logic [15:0] c2, input logic [7:0] l);
      @(posedge pclk);
      w0 <= c0;
      w2 <= c2;
      lat <= l;
      nrd = 0;
      apb(1'b1, `FSG_OFF_RELOAD, 32'h1);
      wait_load();
   endtask : load
   function automatic logic exp_blk(input logic [15:0] c0, c2, input logic [23:0] a);
      logic [14:0] p;
      p = a[23:9];
      if (!c0[1])
         return 1'b1;
      if (c2[0])
         return 1'b0;
      // last page is protected whatever the boundary settings
      if (!c2[2] && p == 15'(`FSG_LAST_ADDR >> `FSG_PAGE_SHIFT))
         return 1'b1;
      return c2[1] ? (p >= c2[15:8]) : (p <= c2[15:8]);
   endfunction : exp_blk
   task t_guard(input logic [15:0] c0, input logic [15:0] c2, input logic [7:0] l);
      load(c0, c2, l);
      for (int i = 0; i < 9; i++)
      begin
         wreq(addrs[i], i[0], b);
         chk(b, exp_blk(c0, c2, addrs[i]));
      end
   endtask : t_guard
   task t_preload;
      wreq(24'h000100, 1'b0, b);
      chk(b, 32'h1);
      ext(`FSG_CFG_BASE, 1'b1);
      wait_load();
   endtask : t_preload
   task t_regs;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {16'h0, w0});
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h1234);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {16'h0, w2});
      apb(1'b0, 8'h14, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
   endtask : t_regs
   task t_ext;
      load(16'hFFFE, 16'hFFFF, 8'h03);
      ext(`FSG_CFG_BASE, 1'b1);
      ext(`FSG_CFG_BASE + 24'h2, 1'b1);
      load(16'hFFFF, 16'hFFFF, 8'h00);
      ext(`FSG_CFG_BASE, 1'b0);
   endtask : t_ext
   initial
   begin
      {psel, penable, pwrite, ext_req} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_addr = 24'h0;
      wr_req = '0;
      w0 = 16'hFFFF;
      w2 = 16'hFFFF;
      lat = 8'h14;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_preload();
      t_regs();
      t_ext();
      t_guard(16'hFFFF, 16'hFFFF, 8'h00);
      t_guard(16'hFFFD, 16'hFFFF, 8'h05);
      t_guard(16'hFFFF, 16'h4006, 8'h00);
      t_guard(16'hFFFF, 16'h4004, 8'h05);
      t_guard(16'hFFFF, 16'h4000, 8'h00);
      t_guard(16'hFFFD, 16'h4006, 8'h01);
      chk({parity_err, dev_reset_req}, 32'h0);
      end_sim();
   end
endmodule : tb
